// ---- core/acec_core.sv ----
/*
 Digital control and event logic around an analog comparator: enable,
 reference selection, output sampling, edge events, sticky flag, interrupt
 and output pin drive.
 Assumes an analog core that compares the selected inputs and returns an
 asynchronous level, and a bus master with one-cycle strobes.
*/
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "acec_defines.svh"

module acec_core (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire acec_pkg::acec_addr_t addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic cmp_raw_i,
    output logic cmp_enable_o,
    output logic ref_select_o,
    output logic cmp_out_pin_o,
    output logic irq_o
);
    import acec_pkg::*;

    acec_state_t s_q, s_d;

    // Level read back through the status/control register
    function automatic logic live_level(input acec_state_t s);
        return s.enable & s.prev;
    endfunction

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    // One process computes everything; the register copy below holds it.
    always_comb begin
        logic rise;
        logic fall;
        logic hit;
        logic sc_wr;
        rise = 1'b0;
        fall = 1'b0;
        hit = 1'b0;
        sc_wr = wr_i && (addr_i == `ACEC_OFS_SC);
        s_d = s_q;

        // Two-stage synchroniser, only the second stage is inspected
        s_d.sync1 = cmp_raw_i;
        s_d.sync2 = s_q.sync1;
        // Disabled comparator presents a 0 so no stale edge survives
        s_d.prev = s_q.enable ? s_q.sync2 : 1'b0;

        // Edges are judged on successive synchronised samples
        rise = s_q.enable && s_q.enable && s_q.sync2 && !s_q.prev;
        fall = s_q.enable && !s_q.sync2 && s_q.prev;
        case (s_q.mode)
            ACEC_MODE_RISE: hit = rise;
            ACEC_MODE_BOTH: hit = rise | fall;
            ACEC_MODE_FALL, ACEC_MODE_FALL2: hit = fall;
            default: hit = 1'b0;
        endcase

        // Control fields, all in one byte
        if (sc_wr) begin
            s_d.enable = wdata_i[`ACEC_BIT_ENABLE];
            s_d.refsel = wdata_i[`ACEC_BIT_REFSEL];
            s_d.irqen = wdata_i[`ACEC_BIT_IRQEN];
            s_d.pinen = wdata_i[`ACEC_BIT_PINEN];
            s_d.mode = acec_mode_t'(wdata_i[`ACEC_MODE_HI:`ACEC_MODE_LO]);
            // Only a one clears; zero leaves the flag alone
            if (wdata_i[`ACEC_BIT_FLAG]) begin
                s_d.flag = 1'b0;
            end
        end
        // Set wins over a clearing write in the same cycle
        if (hit) begin
            s_d.flag = 1'b1;
        end

        // Raw edge status, write-one-to-clear, set wins
        if (wr_i && addr_i == `ACEC_OFS_STAT) begin
            s_d.ev_stat = s_q.ev_stat & ~wdata_i[`ACEC_EV_W-1:0];
        end
        if (rise) begin
            s_d.ev_stat[`ACEC_EV_RISE] = 1'b1;
        end
        if (fall) begin
            s_d.ev_stat[`ACEC_EV_FALL] = 1'b1;
        end
        if (wr_i && addr_i == `ACEC_OFS_MASK) begin
            s_d.ev_mask = wdata_i[`ACEC_EV_W-1:0];
        end

        // Interrupt follows the registered flag and enable, or any event status bit whose mask bit is set
        s_d.irq = (s_d.irqen && s_d.flag) || |(s_d.ev_stat & s_d.ev_mask);

        // Pin shows the synchronised result only while enabled
        s_d.cmp_pin = s_d.pinen && s_d.enable && s_d.prev;
        // Analog core controls: enable and reference mux
        s_d.cmp_en_out = s_d.enable;
        s_d.ref_sel_out = s_d.refsel;

        // Read data stands in the cycle after the strobe only
        s_d.rdata = 8'h00;
        if (rd_i) begin
            case (addr_i)
                `ACEC_OFS_SC: s_d.rdata = {s_q.enable, s_q.refsel, s_q.flag, s_q.irqen,
                                           live_level(s_q), s_q.pinen, s_q.mode};
                `ACEC_OFS_STAT: s_d.rdata = {6'h00, s_q.ev_stat};
                `ACEC_OFS_MASK: s_d.rdata = {6'h00, s_q.ev_mask};
                default: s_d.rdata = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata_o = s_q.rdata;
    assign irq_o = s_q.irq;
    assign cmp_out_pin_o = s_q.cmp_pin;
    assign cmp_enable_o = s_q.cmp_en_out;
    assign ref_select_o = s_q.ref_sel_out;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    property p_flag_set;
        @(posedge clk_i) disable iff (!rst_n_i)
        (s_q.enable && s_q.mode == ACEC_MODE_RISE && s_q.sync2 && !s_q.prev) |=> s_q.flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("rise event did not set flag");

    property p_flag_hold;
        @(posedge clk_i) disable iff (!rst_n_i)
        (s_q.flag && !(wr_i && addr_i == `ACEC_OFS_SC && wdata_i[`ACEC_BIT_FLAG])) |=> s_q.flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without clear");

    property p_irq;
        @(posedge clk_i) disable iff (!rst_n_i)
        (s_q.irqen && s_q.flag) |-> irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing with flag set");

    property p_no_irq;
        @(posedge clk_i) disable iff (!rst_n_i)
        (!s_q.irqen && !(|(s_q.ev_stat & s_q.ev_mask))) |-> !irq_o;
    endproperty
    a_no_irq: assert property (p_no_irq) else $error("irq without cause");

    property p_level_zero;
        @(posedge clk_i) disable iff (!rst_n_i)
        (rd_i && addr_i == `ACEC_OFS_SC && !s_q.enable) |=> !rdata_o[`ACEC_BIT_LEVEL];
    endproperty
    a_level_zero: assert property (p_level_zero) else $error("level read nonzero while off");

    property p_pin_off;
        @(posedge clk_i) disable iff (!rst_n_i)
        !s_q.pinen |-> !cmp_out_pin_o;
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("pin driven while disabled");

    property p_enable_follow;
        @(posedge clk_i) disable iff (!rst_n_i)
        (wr_i && addr_i == `ACEC_OFS_SC) |=> (cmp_enable_o == $past(wdata_i[`ACEC_BIT_ENABLE]));
    endproperty
    a_enable_follow: assert property (p_enable_follow) else $error("enable not applied");

    property p_fall_mode;
        @(posedge clk_i) disable iff (!rst_n_i)
        (s_q.enable && s_q.mode == ACEC_MODE_FALL2 && !s_q.sync2 && s_q.prev) |=> s_q.flag;
    endproperty
    a_fall_mode: assert property (p_fall_mode) else $error("falling edge missed in mode 10");

    property p_sync;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_q.enable |=> (s_q.prev == $past(s_q.sync2));
    endproperty
    a_sync: assert property (p_sync) else $error("sample chain broken");

    c_rise: cover property (@(posedge clk_i) disable iff (!rst_n_i) s_q.flag && s_q.mode == ACEC_MODE_RISE);
    c_both: cover property (@(posedge clk_i) disable iff (!rst_n_i) s_q.flag && s_q.mode == ACEC_MODE_BOTH);
    c_irq: cover property (@(posedge clk_i) disable iff (!rst_n_i) irq_o);
    c_pin: cover property (@(posedge clk_i) disable iff (!rst_n_i) cmp_out_pin_o);
endmodule // acec_core

`default_nettype wire

// ---- core/acec_defines.svh ----
/*
 Constants of the analog compare event control block: register offsets, field
 positions, reset values and interrupt/status layout.
 Assumes inclusion by bare name from the package and the core module.
*/
//
// Contract
// - Setting comparator_enable turns the comparator function on, clearing it keeps it off.
// - reference_select routes the external pin when 0 and the bandgap reference when 1.
// - compare_event_flag is set by each selected compare event and cleared only by writing a one.
// - The interrupt is asserted while compare_irq_enable and compare_event_flag are both set.
// - comparator_output_level reads the present output and is forced to 0 while disabled.
// - output_pin_enable presents the comparator result on comparator_output_pin.
// - event_mode_select 00 and 10 pick falling edges, 01 rising edges, 11 either edge.
// - The output is high when the non-inverting input exceeds the inverting input.
// - All controls of one instance live in a single 8-bit status and control register; the event mask has its own register at offset 2.
`ifndef ACEC_DEFINES_SVH
`define ACEC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define ACEC_ADDR_W 4
`define ACEC_OFS_SC 4'h0
`define ACEC_OFS_STAT 4'h1
`define ACEC_OFS_MASK 4'h2

// ----------------------------------------------------------------------------
// Status and control fields
// ----------------------------------------------------------------------------
`define ACEC_BIT_ENABLE 7
`define ACEC_BIT_REFSEL 6
`define ACEC_BIT_FLAG 5
`define ACEC_BIT_IRQEN 4
`define ACEC_BIT_LEVEL 3
`define ACEC_BIT_PINEN 2
`define ACEC_MODE_HI 1
`define ACEC_MODE_LO 0
`define ACEC_SC_RESET 8'h00
`define ACEC_SC_WMASK 8'hD7

// ----------------------------------------------------------------------------
// Event status/mask layout
// ----------------------------------------------------------------------------
`define ACEC_EV_W 2
`define ACEC_EV_RISE 0
`define ACEC_EV_FALL 1
`define ACEC_MASK_RESET 2'h0

`endif

// ---- core/acec_pkg.sv ----
/*
 Types of the analog compare event control block.
 Assumes the defines header sits on the include path.
*/
`include "acec_defines.svh"

package acec_pkg;
    // Event selection encodings
    typedef enum logic [1:0] {
        ACEC_MODE_FALL = 2'b00,
        ACEC_MODE_RISE = 2'b01,
        ACEC_MODE_FALL2 = 2'b10,
        ACEC_MODE_BOTH = 2'b11
    } acec_mode_t;

    typedef logic [`ACEC_ADDR_W-1:0] acec_addr_t;

    // Whole block state
    typedef struct packed {
        logic enable;
        logic refsel;
        logic flag;
        logic irqen;
        logic pinen;
        acec_mode_t mode;
        logic sync1;
        logic sync2;
        logic prev;
        logic [`ACEC_EV_W-1:0] ev_stat;
        logic [`ACEC_EV_W-1:0] ev_mask;
        logic [7:0] rdata;
        logic irq;
        logic cmp_pin;
        logic ref_sel_out;
        logic cmp_en_out;
    } acec_state_t;
endpackage

// ---- verification/acec_cmp_model.sv ----
/*
 Behavioural model of the analog comparator core and its input pins.
 Assumes pin voltages are given as integer millivolts by the bench.
*/
`timescale 1ns/1ps
`default_nettype none

module acec_cmp_model (
    input wire logic clk_i,
    input wire logic enable_i,
    input wire logic ref_select_i,
    input var int vplus_i,
    input var int vminus_i,
    input var int vbg_i,
    output logic raw_o
);
    // Select the non-inverting source, then compare against the inverting pin
    // A powered-down core rests low, so enabling with a high input shows a rising edge
    always_comb begin
        if (!enable_i) begin
            raw_o = 1'b0;
        end else begin
            raw_o = ((ref_select_i ? vbg_i : vplus_i) > vminus_i);
        end
    end
endmodule // acec_cmp_model

`default_nettype wire

// ---- verification/tb.sv ----
/*
 Self-checking bench of the analog compare event control block.
 Assumes the core, its package and the comparator model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "acec_defines.svh"
`define CHK(n, x, y) begin comparisons++; if ((y) !== (x)) begin mismatches++; \
    $display("wrong value %s exp %h got %h", n, x, y); end end

module tb;
    import acec_pkg::*;
    logic clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, rd_seen = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00, rdata_o, got_exp;
    logic cmp_raw_i, cmp_enable_o, ref_select_o, cmp_out_pin_o, irq_o, fr, ff;
    logic [1:0] md;
    logic [7:0] notes[$];
    int vplus = 0, vminus = 0, vbg = 0, mismatches = 0, comparisons = 0, seed;

    always #2 clk_i = ~clk_i;

    acec_core DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .cmp_raw_i(cmp_raw_i), .cmp_enable_o(cmp_enable_o),
        .ref_select_o(ref_select_o), .cmp_out_pin_o(cmp_out_pin_o), .irq_o(irq_o));
    acec_cmp_model u_model (.clk_i(clk_i), .enable_i(cmp_enable_o), .ref_select_i(ref_select_o),
        .vplus_i(vplus), .vminus_i(vminus), .vbg_i(vbg), .raw_o(cmp_raw_i));

    // ------------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // The expected value is noted as the strobe goes out
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        notes.push_back(e);
        @(posedge clk_i);
        rd_i <= 1'b0;
    endtask
    // Covers the two-flop sync plus detect and flag stages with margin
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Read monitor: data stand only in the cycle after the strobe
    // ------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rd_seen) begin
            got_exp = (notes.size() > 0) ? notes.pop_front() : 8'hXX;
            `CHK("rdata", got_exp, rdata_o)
        end
        rd_seen = rd_i;
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        finish_test();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        seed = $urandom(32'h5266be46);
        vminus = $urandom_range(1000, 200);
        vbg = vminus - 20;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(`ACEC_OFS_SC, `ACEC_SC_RESET);
        rd(`ACEC_OFS_MASK, 8'h00);
        wr(4'hF, 8'($urandom()));
        rd(4'hF, 8'h00);
        $display("test reset done");
        // Disabled: level and pin stay low although the input is high
        vplus = vminus + 1 + $urandom_range(100);
        wr(`ACEC_OFS_SC, 8'h04);
        cyc(6);
        rd(`ACEC_OFS_SC, 8'h04);
        `CHK("pin", 1'b0, cmp_out_pin_o)
        `CHK("enable", 1'b0, cmp_enable_o)
        wr(`ACEC_OFS_SC, 8'h84);
        cyc(6);
        rd(`ACEC_OFS_SC, 8'h8C);
        `CHK("pin", 1'b1, cmp_out_pin_o)
        `CHK("enable", 1'b1, cmp_enable_o)
        $display("test enable done");
        // Bandgap source: the external pin no longer matters
        vbg = vminus + 20;
        wr(`ACEC_OFS_SC, 8'hC0);
        cyc(6);
        vplus = vminus - 1 - $urandom_range(100);
        cyc(6);
        rd(`ACEC_OFS_SC, 8'hC8);
        `CHK("refsel", 1'b1, ref_select_o)
        vbg = vminus - 20;
        cyc(6);
        rd(`ACEC_OFS_SC, 8'hE0);
        `CHK("irq", 1'b0, irq_o)
        $display("test reference done");
        // Every event mode, rising then falling edge
        for (int m = 0; m < 4; m++) begin
            md = 2'(m);
            fr = md[0];
            ff = (md != ACEC_MODE_RISE);
            vplus = vminus - 10;
            wr(`ACEC_OFS_SC, 8'hB0 | md);
            cyc(6);
            rd(`ACEC_OFS_SC, 8'h90 | md);
            vplus = vminus + 10;
            cyc(6);
            rd(`ACEC_OFS_SC, 8'h98 | md | {fr, 5'h00});
            `CHK("irq", fr, irq_o)
            wr(`ACEC_OFS_SC, 8'h90 | md);
            rd(`ACEC_OFS_SC, 8'h98 | md | {fr, 5'h00});
            wr(`ACEC_OFS_SC, 8'hB0 | md);
            vplus = vminus - 10;
            cyc(6);
            rd(`ACEC_OFS_SC, 8'h90 | md | {ff, 5'h00});
            `CHK("irq", ff, irq_o)
        end
        $display("test modes done");
        // Event status and mask drive the interrupt with irq enable off
        wr(`ACEC_OFS_SC, 8'hA0);
        wr(`ACEC_OFS_STAT, 8'h03);
        wr(`ACEC_OFS_MASK, 8'h01);
        rd(`ACEC_OFS_MASK, 8'h01);
        vplus = vminus + 10;
        cyc(6);
        rd(`ACEC_OFS_STAT, 8'h01);
        `CHK("irq", 1'b1, irq_o)
        wr(`ACEC_OFS_STAT, 8'h01);
        rd(`ACEC_OFS_STAT, 8'h00);
        `CHK("irq", 1'b0, irq_o)
        vplus = vminus - 10;
        cyc(6);
        rd(`ACEC_OFS_STAT, 8'h02);
        `CHK("irq", 1'b0, irq_o)
        $display("test events done");
        cyc(3);
        finish_test();
    end
endmodule // tb

`default_nettype wire
